// *** rtl/emt_top.sv ***
// Contract
// R1: dram timing bit 0 fast, 1 slow
// R2: 8-bit word uses bits 23-16
// R3: 16-bit word uses bits 23-8
// R4: 20-bit on 4-bit bus uses 23-4
// R5: 20/24/12-bit words left-justified in word
// R6: byte per step wide, nibble narrow
// R7: fast dram: 3 setup, 3/part, 2 finish
// R8: slow dram: 4 setup, 4/part, 4 finish
// R9: sram access: 2 setup, 1-16 wait, 1 final
// R10: sram: one to six accesses per word
// R11: stop holds reset state, clears status only
// R12: each sequence step is one clock
`timescale 1ns/1ns
`default_nettype none
module emt_top (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_STOP,
    input wire logic [4:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [17:0] O_MEM_ADDR,
    output logic O_MEM_ROW_SEL_N,
    output logic O_MEM_COL_SEL_N,
    output logic O_MEM_CHIP_SEL_N,
    output logic O_MEM_WE_N,
    output logic O_MEM_OE_N,
    output logic [7:0] O_MEM_DQ,
    output logic O_MEM_DQ_OE,
    input wire logic [7:0] I_MEM_DQ
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_r; // first stage
    logic rst_n_r;    // released reset used by all logic

    // two-stage release, async assert
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [11:0] ctrl_r;      // control bits
    logic [17:0] addr_r;      // memory word address
    logic [23:0] wdata_r;     // word to write
    logic [23:0] rdata_r;     // read word
    logic busy_r;             // access running
    logic rdone_r;            // read data ready
    logic wdone_r;            // write finished
    logic is_rd_r;            // current access is a read
    logic rd_ack_r;           // bus read answered this cycle
    logic [31:0] rd_q_r;      // registered bus read data
    emt_pkg::emt_state_e state_r;
    emt_pkg::emt_state_e state_nxt;
    logic [2:0] part_r;       // part index, msb first
    logic [2:0] part_nxt;

    // ----------------------------------------
    // control field views
    // ----------------------------------------
    wire slow = ctrl_r[emt_pkg::CTRL_SLOW_BIT];
    wire sram = ctrl_r[emt_pkg::CTRL_SRAM_BIT];
    wire bus8 = ctrl_r[emt_pkg::CTRL_BUS8_BIT];
    wire [2:0] len = ctrl_r[emt_pkg::CTRL_LEN_LSB +: 3];
    wire [3:0] wait_fld = ctrl_r[emt_pkg::CTRL_WAIT_LSB +: 4];

    // ----------------------------------------
    // parts per word
    // ----------------------------------------
    // wide bus: 8 -> 1, 12/16 -> 2, 20/24 -> 3 bytes (see R2) (see R3) (see R5)
    wire [2:0] parts8 = (len == emt_pkg::LEN_8) ? 3'h1 :
                        (len == emt_pkg::LEN_12 || len == emt_pkg::LEN_16) ? 3'h2 : 3'h3;
    // narrow bus: 8 -> 2, 12 -> 3, 16 -> 4, 20 -> 5 (low nibble unused), 24 -> 6 (see R4) (see R5)
    wire [2:0] parts4 = (len == emt_pkg::LEN_8) ? 3'h2 :
                        (len == emt_pkg::LEN_12) ? 3'h3 :
                        (len == emt_pkg::LEN_16) ? 3'h4 :
                        (len == emt_pkg::LEN_20) ? 3'h5 : 3'h6;
    // sram: one access per part (see R10)
    wire [2:0] nparts = bus8 ? parts8 : parts4;
    wire last_part = (part_r == nparts - 3'h1);

    // ----------------------------------------
    // phase lengths
    // ----------------------------------------
    // dram phase lengths (see R1) (see R7) (see R8)
    wire [4:0] dram_setup = slow ? emt_pkg::DRAM_SLOW_SETUP : emt_pkg::DRAM_FAST_SETUP;
    wire [4:0] dram_part = slow ? emt_pkg::DRAM_SLOW_PART : emt_pkg::DRAM_FAST_PART;
    wire [4:0] dram_fin = slow ? emt_pkg::DRAM_SLOW_FINISH : emt_pkg::DRAM_FAST_FINISH;
    // wait field 0..15 gives 1..16 cycles (see R9)
    wire [4:0] sram_xfer = {1'b0, wait_fld} + 5'h01;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire hit_ctrl = (I_AVS_ADDRESS == emt_pkg::REG_CTRL);
    wire hit_stat = (I_AVS_ADDRESS == emt_pkg::REG_STATUS);
    wire hit_addr = (I_AVS_ADDRESS == emt_pkg::REG_ADDR);
    wire hit_wdata = (I_AVS_ADDRESS == emt_pkg::REG_WDATA);
    wire hit_rdata = (I_AVS_ADDRESS == emt_pkg::REG_RDATA);
    wire hit_rdtrig = (I_AVS_ADDRESS == emt_pkg::REG_RDTRIG);
    // ctrl, addr, wdata and rdtrig writes stall while busy, never drop
    wire wr_hold = busy_r && (hit_ctrl || hit_addr || hit_wdata || hit_rdtrig);
    wire wr_take = I_AVS_WRITE && !wr_hold && !I_STOP;
    wire start_wr = wr_take && hit_wdata;
    wire start_rd = wr_take && hit_rdtrig;
    wire start = start_wr || start_rd;
    wire rd_take = I_AVS_READ && rd_ack_r;

    // reads take one wait state
    assign O_AVS_WAITREQUEST = (I_AVS_READ && !rd_ack_r) || (I_AVS_WRITE && (wr_hold || I_STOP));
    assign O_AVS_READDATA = rd_q_r;

    // read mux, unmapped reads zero
    wire [31:0] rd_mux = hit_ctrl ? {20'h00000, ctrl_r} :
                         hit_stat ? {29'h00000000, wdone_r, rdone_r, busy_r} :
                         hit_addr ? {14'h0000, addr_r} :
                         hit_wdata ? {8'h00, wdata_r} :
                         hit_rdata ? {8'h00, rdata_r} : 32'h00000000;

    // ----------------------------------------
    // data lanes
    // ----------------------------------------
    wire [7:0] lane;
    wire [23:0] merged;

    emt_align u_align (
        .i_bus8(bus8),
        .i_part(part_r),
        .i_word(wdata_r),
        .i_asm(rdata_r),
        .i_dq(I_MEM_DQ),
        .o_lane(lane),
        .o_merged(merged)
    );

    // ----------------------------------------
    // phase counter
    // ----------------------------------------
    wire ph_last;
    logic ph_load;
    logic [4:0] ph_len;

    emt_cycle_cnt u_cnt (
        .i_clk(I_REF_CLK),
        .i_rst_n(rst_n_r),
        .i_load(ph_load),
        .i_len(ph_len),
        .o_last(ph_last)
    );

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    // one clock per numbered step (see R12)
    always_comb begin
        state_nxt = state_r;
        part_nxt = part_r;
        ph_load = 1'b0;
        ph_len = 5'h01;
        case (state_r)
            emt_pkg::ST_IDLE: begin
                // new access opens with setup
                if (start) begin
                    state_nxt = emt_pkg::ST_SETUP;
                    part_nxt = 3'h0;
                    ph_load = 1'b1;
                    ph_len = sram ? emt_pkg::SRAM_SETUP : dram_setup; // see R9
                end
            end
            emt_pkg::ST_SETUP: begin
                // setup done, first transfer
                if (ph_last) begin
                    state_nxt = emt_pkg::ST_XFER;
                    ph_load = 1'b1;
                    ph_len = sram ? sram_xfer : dram_part; // see R7 see R8 see R9
                end
            end
            emt_pkg::ST_XFER: begin
                if (ph_last) begin
                    if (sram || last_part) begin
                        // sram closes every access with its final cycle
                        state_nxt = emt_pkg::ST_FINISH;
                        ph_load = 1'b1;
                        ph_len = sram ? emt_pkg::SRAM_FINISH : dram_fin; // see R7 see R8
                    end else begin
                        // dram keeps the row open
                        part_nxt = part_r + 3'h1;
                        ph_load = 1'b1;
                        ph_len = dram_part;
                    end
                end
            end
            emt_pkg::ST_FINISH: begin
                if (ph_last) begin
                    if (sram && !last_part) begin
                        // next sram access, next part (see R10)
                        state_nxt = emt_pkg::ST_SETUP;
                        part_nxt = part_r + 3'h1;
                        ph_load = 1'b1;
                        ph_len = emt_pkg::SRAM_SETUP;
                    end else begin
                        state_nxt = emt_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = emt_pkg::ST_IDLE;
            end
        endcase
    end

    wire xfer_end = (state_r == emt_pkg::ST_XFER) && ph_last;
    wire word_end = (state_r == emt_pkg::ST_FINISH) && ph_last && (state_nxt == emt_pkg::ST_IDLE);

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    // stop parks the sequencer (see R11)
    always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= emt_pkg::ST_IDLE;
            part_r <= 3'h0;
        end else if (I_STOP) begin
            state_r <= emt_pkg::ST_IDLE;
            part_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            part_r <= part_nxt;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // control survives stop (see R11)
    always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= emt_pkg::CTRL_RESET;
            addr_r <= 18'h00000;
            wdata_r <= 24'h000000;
        end else begin
            if (wr_take && hit_ctrl) begin
                ctrl_r <= I_AVS_WRITEDATA[11:0];
            end
            if (wr_take && hit_addr) begin
                addr_r <= I_AVS_WRITEDATA[17:0];
            end
            if (start_wr) begin
                wdata_r <= I_AVS_WRITEDATA[23:0];
            end
        end
    end

    // ----------------------------------------
    // status and read assembly
    // ----------------------------------------
    // completion beats a clear
    always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            busy_r <= 1'b0;
            rdone_r <= 1'b0;
            wdone_r <= 1'b0;
            is_rd_r <= 1'b0;
            rdata_r <= 24'h000000;
        end else if (I_STOP) begin
            busy_r <= 1'b0;   // see R11
            rdone_r <= 1'b0;
            wdone_r <= 1'b0;
        end else begin
            if (start) begin
                busy_r <= 1'b1;
                is_rd_r <= start_rd;
                wdone_r <= 1'b0;
                rdone_r <= 1'b0;
            end else if (word_end) begin
                busy_r <= 1'b0;
                rdone_r <= is_rd_r ? 1'b1 : rdone_r;
                wdone_r <= !is_rd_r;
            end else if (rd_take && hit_rdata) begin
                rdone_r <= 1'b0;
            end
            if (start_rd) begin
                rdata_r <= 24'h000000; // low bits stay zero
            end else if (xfer_end && is_rd_r) begin
                // take the part at step end (see R6)
                rdata_r <= merged;
            end
        end
    end

    // ----------------------------------------
    // bus read answer
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_ack_r <= 1'b0;
            rd_q_r <= 32'h00000000;
        end else begin
            rd_ack_r <= I_AVS_READ && !rd_ack_r;
            rd_q_r <= rd_mux;
        end
    end

    // ----------------------------------------
    // memory pins
    // ----------------------------------------
    wire in_setup = (state_r == emt_pkg::ST_SETUP);
    wire in_xfer = (state_r == emt_pkg::ST_XFER);
    wire in_fin = (state_r == emt_pkg::ST_FINISH);
    wire [8:0] col = addr_r[8:0] + {6'h00, part_r};

    // dram row then column; sram address per part
    assign O_MEM_ADDR = sram ? (addr_r + {15'h0000, part_r}) :
                        in_setup ? {9'h000, addr_r[17:9]} : {9'h000, col};
    assign O_MEM_ROW_SEL_N = !(!sram && (in_xfer || in_fin));
    assign O_MEM_COL_SEL_N = !(!sram && in_xfer);
    assign O_MEM_CHIP_SEL_N = !(sram && (in_setup || in_xfer || in_fin));
    assign O_MEM_WE_N = !(in_xfer && !is_rd_r);
    assign O_MEM_OE_N = !(in_xfer && is_rd_r);
    assign O_MEM_DQ = (in_xfer && !is_rd_r) ? lane : 8'h00;
    assign O_MEM_DQ_OE = in_xfer && !is_rd_r;
endmodule // emt_top
`default_nettype wire

// *** shared/emt_pkg.sv ***
`default_nettype none
package emt_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;    // control bits
    localparam logic [4:0] REG_STATUS = 5'h04;  // status bits, read only
    localparam logic [4:0] REG_ADDR = 5'h08;    // memory word address
    localparam logic [4:0] REG_WDATA = 5'h0C;   // write data, starts write
    localparam logic [4:0] REG_RDATA = 5'h10;   // assembled read data
    localparam logic [4:0] REG_RDTRIG = 5'h14;  // write starts a read

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTRL_SLOW_BIT = 0;     // dram_slow_timing_select
    localparam int CTRL_SRAM_BIT = 1;     // sram modes
    localparam int CTRL_BUS8_BIT = 2;     // 8-bit memory bus
    localparam int CTRL_LEN_LSB = 4;      // word length code, 3 bits
    localparam int CTRL_WAIT_LSB = 8;     // sram_wait_count_field, 4 bits
    localparam logic [11:0] CTRL_RESET = 12'h000;

    // ----------------------------------------
    // status field positions
    // ----------------------------------------
    localparam int STAT_BUSY_BIT = 0;     // access in progress
    localparam int STAT_RDONE_BIT = 1;    // read data ready
    localparam int STAT_WDONE_BIT = 2;    // write finished

    // ----------------------------------------
    // word length codes
    // ----------------------------------------
    localparam logic [2:0] LEN_8 = 3'h0;
    localparam logic [2:0] LEN_12 = 3'h1;
    localparam logic [2:0] LEN_16 = 3'h2;
    localparam logic [2:0] LEN_20 = 3'h3;
    localparam logic [2:0] LEN_24 = 3'h4;

    // ----------------------------------------
    // cycle counts per phase
    // ----------------------------------------
    localparam logic [4:0] DRAM_FAST_SETUP = 5'h03;
    localparam logic [4:0] DRAM_FAST_PART = 5'h03;
    localparam logic [4:0] DRAM_FAST_FINISH = 5'h02;
    localparam logic [4:0] DRAM_SLOW_SETUP = 5'h04;
    localparam logic [4:0] DRAM_SLOW_PART = 5'h04;
    localparam logic [4:0] DRAM_SLOW_FINISH = 5'h04;
    localparam logic [4:0] SRAM_SETUP = 5'h02;
    localparam logic [4:0] SRAM_FINISH = 5'h01;

    // ----------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_XFER = 4'b0100,
        ST_FINISH = 4'b1000
    } emt_state_e;
endpackage
`default_nettype wire

// *** rtl/emt_cycle_cnt.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// phase length counter
// ----------------------------------------
module emt_cycle_cnt (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [4:0] i_len,
    output logic o_last
);
    logic [4:0] cnt_r; // cycles left in the phase

    // load on entry, count down to one
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 5'h01;
        end else if (i_load) begin
            cnt_r <= i_len;
        end else if (cnt_r != 5'h01) begin
            cnt_r <= cnt_r - 5'h01;
        end
    end

    // last cycle of the phase
    assign o_last = (cnt_r == 5'h01);
endmodule // emt_cycle_cnt
`default_nettype wire

// *** rtl/emt_align.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// left-justified lane select and merge
// ----------------------------------------
module emt_align (
    input wire logic i_bus8,
    input wire logic [2:0] i_part,
    input wire logic [23:0] i_word,
    input wire logic [23:0] i_asm,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_lane,
    output logic [23:0] o_merged
);
    // part offset below bit 23, msb part first
    wire [4:0] byte_sh = 5'(i_part) << 3;
    wire [4:0] nib_sh = 5'(i_part) << 2;
    wire [23:0] word_b = i_word << byte_sh;
    wire [23:0] word_n = i_word << nib_sh;
    wire [23:0] ins_b = {i_dq, 16'h0000} >> byte_sh;
    wire [23:0] ins_n = {i_dq[3:0], 20'h00000} >> nib_sh;
    wire [23:0] msk_b = 24'hFF0000 >> byte_sh;
    wire [23:0] msk_n = 24'hF00000 >> nib_sh;

    // byte per step wide, nibble narrow (see R6)
    assign o_lane = i_bus8 ? word_b[23:16] : {4'h0, word_n[23:20]};
    assign o_merged = i_bus8 ? ((i_asm & ~msk_b) | ins_b) : ((i_asm & ~msk_n) | ins_n);
endmodule // emt_align
`default_nettype wire

// *** testbench/emt_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// external memory model
// ----------------------------------------
module emt_mem_model (
    input wire logic i_clk,
    input wire logic [17:0] i_addr,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    logic [7:0] mem_r [0:1023]; // storage
    logic [7:0] last_r; // last value seen on the data lines
    wire [9:0] idx_w = i_addr[9:0]; // row bits ignored
    // clear storage so a bad read never matches by luck
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem_r[i] = 8'h00;
        end
        last_r = 8'h5A;
    end
    // store writes, remember the bus
    always @(posedge i_clk) begin
        if (!i_we_n) begin
            mem_r[idx_w] <= i_dq;
        end
        last_r <= o_dq;
    end
    // released lines show the inverse
    assign o_dq = !i_oe_n ? mem_r[idx_w] : ~last_r;
endmodule // emt_mem_model
`default_nettype wire

// *** testbench/emt_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module emt_chk (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_STOP,
    input wire logic [4:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_MEM_ROW_SEL_N,
    input wire logic O_MEM_COL_SEL_N,
    input wire logic O_MEM_CHIP_SEL_N,
    input wire logic O_MEM_WE_N,
    input wire logic O_MEM_OE_N,
    input wire logic [7:0] O_MEM_DQ,
    input wire logic O_MEM_DQ_OE
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [11:0] ctrl_r; // snooped control
    logic [4:0] run_r; // strobe low run
    wire take_w = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    wire trig_w = take_w && (I_AVS_ADDRESS == emt_pkg::REG_WDATA || I_AVS_ADDRESS == emt_pkg::REG_RDTRIG);
    wire strobe_n = O_MEM_WE_N && O_MEM_OE_N;
    wire sram_w = ctrl_r[emt_pkg::CTRL_SRAM_BIT];
    wire slow_w = ctrl_r[emt_pkg::CTRL_SLOW_BIT];
    wire [4:0] wait_w = {1'b0, ctrl_r[11:8]} + 5'h01; // field 0 means one cycle
    // snoop control and time the strobe run
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_r <= 12'h000;
            run_r <= 5'h00;
        end else begin
            if (take_w && I_AVS_ADDRESS == emt_pkg::REG_CTRL) begin
                ctrl_r <= I_AVS_WRITEDATA[11:0];
            end
            run_r <= strobe_n ? 5'h00 : run_r + 5'h01;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // stop aborts any sequence, so it disables the timing checks
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N || I_STOP);
    sequence s_setup3; O_MEM_ROW_SEL_N [*3] ##1 !O_MEM_ROW_SEL_N; endsequence
    sequence s_setup4; O_MEM_ROW_SEL_N [*4] ##1 !O_MEM_ROW_SEL_N; endsequence
    sequence s_fin2; !O_MEM_ROW_SEL_N [*2] ##1 O_MEM_ROW_SEL_N; endsequence
    sequence s_fin4; !O_MEM_ROW_SEL_N [*4] ##1 O_MEM_ROW_SEL_N; endsequence
    property p_setup_fast; trig_w && !sram_w && !slow_w |=> s_setup3; endproperty
    property p_setup_slow; trig_w && !sram_w && slow_w |=> s_setup4; endproperty
    property p_fin_fast; $rose(O_MEM_COL_SEL_N) && !slow_w |-> s_fin2; endproperty
    property p_fin_slow; $rose(O_MEM_COL_SEL_N) && slow_w |-> s_fin4; endproperty
    property p_sram_setup; trig_w && sram_w |=> (strobe_n && !O_MEM_CHIP_SEL_N) [*2] ##1 !strobe_n; endproperty
    property p_sram_wait; $rose(strobe_n) && sram_w |-> run_r == wait_w && !O_MEM_CHIP_SEL_N; endproperty
    property p_rowcol; !O_MEM_COL_SEL_N |-> !O_MEM_ROW_SEL_N && O_MEM_CHIP_SEL_N; endproperty
    property p_dq;
        (O_MEM_DQ_OE == !O_MEM_WE_N) && (O_MEM_DQ_OE ? (ctrl_r[2] || O_MEM_DQ[7:4] == 4'h0) : O_MEM_DQ == 8'h00);
    endproperty
    property p_read_wait; $rose(I_AVS_READ) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST; endproperty
    property p_stop;
        disable iff (!I_ARST_N) I_STOP |=> O_MEM_ROW_SEL_N && O_MEM_COL_SEL_N && O_MEM_CHIP_SEL_N && !O_MEM_DQ_OE;
    endproperty
    a_setup_fast: assert property (p_setup_fast) else $error("fast setup");
    a_setup_slow: assert property (p_setup_slow) else $error("slow setup");
    a_fin_fast: assert property (p_fin_fast) else $error("fast finish");
    a_fin_slow: assert property (p_fin_slow) else $error("slow finish");
    a_sram_setup: assert property (p_sram_setup) else $error("sram setup");
    a_sram_wait: assert property (p_sram_wait) else $error("sram wait");
    a_rowcol: assert property (p_rowcol) else $error("col outside row");
    a_dq: assert property (p_dq) else $error("data lane");
    a_read_wait: assert property (p_read_wait) else $error("read wait");
    a_stop: assert property (p_stop) else $error("busy in stop");
endmodule // emt_chk
bind emt_top emt_chk u_chk (.I_REF_CLK, .I_ARST_N, .I_STOP, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE,
    .I_AVS_WRITEDATA, .O_AVS_WAITREQUEST, .O_MEM_ROW_SEL_N, .O_MEM_COL_SEL_N, .O_MEM_CHIP_SEL_N,
    .O_MEM_WE_N, .O_MEM_OE_N, .O_MEM_DQ, .O_MEM_DQ_OE);
`default_nettype wire

// *** testbench/test_emt_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_emt_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct {logic [11:0] ctrl; logic [23:0] data; logic [23:0] mask; logic [7:0] a; logic [7:0] b;} emt_row_s;
    logic clk, arst_n, stop, rd, wr, ras_n, cas_n, cs_n, we_n, oe_n, dq_oe, wreq;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [17:0] maddr;
    logic [7:0] dq_out, dq_in;
    int failures, n_tests, cyc, n_row, n_str, da, db;
    // a: select cycles, b: strobe cycles
    emt_row_s rows [9] = '{'{12'h044, 24'hA5C396, 24'hFFFFFF, 8'h0B, 8'h09},
        '{12'h045, 24'h5A3C69, 24'hFFFFFF, 8'h10, 8'h0C}, '{12'h004, 24'hC31234, 24'hFF0000, 8'h05, 8'h03},
        '{12'h024, 24'h96ABCD, 24'hFFFF00, 8'h08, 8'h06}, '{12'h030, 24'hE17BD2, 24'hFFFFF0, 8'h11, 8'h0F},
        '{12'h011, 24'h7E4A5B, 24'hFFF000, 8'h10, 8'h0C}, '{12'h042, 24'h3CA5F0, 24'hFFFFFF, 8'h18, 8'h06},
        '{12'hF06, 24'hB4E1D2, 24'hFF0000, 8'h13, 8'h10}, '{12'h336, 24'h69C350, 24'hFFFFFF, 8'h15, 8'h0C}};
    emt_top dut (.I_REF_CLK(clk), .I_ARST_N(arst_n), .I_STOP(stop), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
        .O_MEM_ADDR(maddr), .O_MEM_ROW_SEL_N(ras_n), .O_MEM_COL_SEL_N(cas_n), .O_MEM_CHIP_SEL_N(cs_n),
        .O_MEM_WE_N(we_n), .O_MEM_OE_N(oe_n), .O_MEM_DQ(dq_out), .O_MEM_DQ_OE(dq_oe), .I_MEM_DQ(dq_in));
    emt_mem_model mem (.i_clk(clk), .i_addr(maddr), .i_we_n(we_n), .i_oe_n(oe_n), .i_dq(dq_out), .o_dq(dq_in));
    // ----------------------------------------
    // clock, cycle counting and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counted mid-cycle, no race
    always @(negedge clk) begin
        if (!ras_n || !cs_n) n_row++;
        if (!(we_n && oe_n)) n_str++;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            stop_test();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle, then a spare edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        {adr, wdat, wr, rd} <= {a, d, w, !w};
        do @(negedge clk); while (wreq !== 1'b0);
        r = rdat;
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(posedge clk);
    endtask
    // trigger, poll busy, count pin cycles
    task access(input logic [4:0] a, input logic [23:0] d, output int ca, output int cb);
        int r0, s0;
        logic [31:0] s;
        r0 = n_row;
        s0 = n_str;
        bus(1'b1, a, {8'h00, d}, s);
        s = 32'h1;
        for (int k = 0; k < 200 && s[emt_pkg::STAT_BUSY_BIT] !== 1'b0; k++) bus(1'b0, emt_pkg::REG_STATUS, 32'h0, s);
        ca = n_row - r0;
        cb = n_str - s0;
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {arst_n, stop, rd, wr, adr, wdat} = '0;
        repeat (2) @(posedge clk);
        chk(32'({ras_n, cas_n, cs_n, we_n, oe_n, dq_oe}), 32'h3E); // pins idle in reset
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, emt_pkg::REG_CTRL, 32'h0, q);
        chk(q, 32'(emt_pkg::CTRL_RESET)); // control reset value
        bus(1'b0, emt_pkg::REG_STATUS, 32'h0, q);
        chk(q, 32'h0); // status clear after reset
        $display("reset test done");
        // each mode: write, read back
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, emt_pkg::REG_CTRL, 32'(rows[i].ctrl), q);
            bus(1'b1, emt_pkg::REG_ADDR, 32'h0, q);
            access(emt_pkg::REG_WDATA, rows[i].data, da, db);
            chk(da, 32'(rows[i].a));
            chk(db, 32'(rows[i].b));
            chk(32'(mem.mem_r[0]), rows[i].ctrl[2] ? 32'(rows[i].data[23:16]) : 32'(rows[i].data[23:20]));
            access(emt_pkg::REG_RDTRIG, 24'h0, da, db);
            chk(da, 32'(rows[i].a));
            chk(db, 32'(rows[i].b));
            bus(1'b0, emt_pkg::REG_RDATA, 32'h0, q);
            chk(q, {8'h00, rows[i].data & rows[i].mask});
            $display("mode row %0d done", i);
        end
        // stop mid access
        bus(1'b1, emt_pkg::REG_CTRL, 32'h044, q);
        bus(1'b1, emt_pkg::REG_WDATA, 32'h123456, q);
        repeat (4) @(posedge clk);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'({ras_n, cas_n, cs_n, dq_oe}), 32'hE);
        bus(1'b0, emt_pkg::REG_STATUS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, emt_pkg::REG_CTRL, 32'h0, q);
        chk(q, 32'h44);
        stop <= 1'b0;
        @(posedge clk);
        $display("stop test done");
        // status read only, unmapped read zero
        bus(1'b1, emt_pkg::REG_STATUS, 32'h7, q);
        bus(1'b0, emt_pkg::REG_STATUS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, 5'h18, 32'h0, q);
        chk(q, 32'h0);
        // back to back writes stall
        bus(1'b1, emt_pkg::REG_WDATA, 32'h111111, q);
        access(emt_pkg::REG_WDATA, 24'hC0FFEE, da, db);
        access(emt_pkg::REG_RDTRIG, 24'h0, da, db);
        chk(da, 32'h0B);
        bus(1'b0, emt_pkg::REG_RDATA, 32'h0, q);
        chk(q, 32'hC0FFEE);
        $display("bus test done");
        stop_test();
    end
endmodule // test_emt_top
`default_nettype wire
